// file: oag_pkg.sv
// Purpose: constants and types for the operand address generator
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes: the mode, post-update and condition codes below are the
//   values that software writes into the control register
package oag_pkg;

  localparam int DW = 16;
  localparam int PW = 8;
  localparam int NPTR = 6;
  localparam int AW = 8;

  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_OPERAND = 8'h04;
  localparam logic [AW-1:0] REG_STATUS = 8'h08;
  localparam logic [AW-1:0] REG_ACC = 8'h0c;
  localparam logic [AW-1:0] REG_RESULT = 8'h10;
  localparam logic [AW-1:0] REG_INFO = 8'h14;
  localparam logic [AW-1:0] REG_PTR_BASE = 8'h20;

  // destination and source selector encoding
  localparam logic [2:0] SEL_ACC = 3'h0;
  localparam logic [2:0] SEL_PTR_FIRST = 3'h1;
  localparam logic [2:0] SEL_RESULT = 3'h7;

  localparam logic [PW-1:0] DREG_PAD = 8'h00;
  localparam logic [DW-1:0] PM_STEP = 16'h0001;
  localparam logic [PW-1:0] PTR_STEP = 8'h01;

  typedef enum logic [3:0] {
    MODE_REG_MOVE,
    MODE_PTR_IND,
    MODE_DREG,
    MODE_PTR_MEM,
    MODE_DREG_MEM,
    MODE_ACC_IND,
    MODE_DIRECT,
    MODE_LONG_IMM,
    MODE_SHORT_IMM
  } oag_mode_type;

  typedef enum logic [1:0] {
    POST_NONE,
    POST_INC,
    POST_LOOP_INC,
    POST_LOOP_DEC
  } oag_post_type;

  typedef enum logic [3:0] {
    CC_ALWAYS,
    CC_NEVER,
    CC_CARRY,
    CC_NO_CARRY,
    CC_ZERO,
    CC_NOT_ZERO,
    CC_NEGATIVE_TEST,
    CC_POSITIVE_TEST,
    CC_OVERFLOW_SET_TEST,
    CC_OVERFLOW_CLEAR_TEST,
    CC_USER_FLAG_ZERO_TEST,
    CC_USER_FLAG_ZERO_CLEAR_TEST,
    CC_USER_FLAG_ONE_TEST,
    CC_USER_FLAG_ONE_CLEAR_TEST,
    CC_INTERRUPTS_ON_TEST,
    CC_INTERRUPTS_OFF_TEST
  } oag_cc_type;

  // aliases share the code of the flag test they stand for
  localparam oag_cc_type CC_UNSIGNED_BELOW_TEST = CC_CARRY;
  localparam oag_cc_type CC_UNSIGNED_AT_LEAST_TEST = CC_NO_CARRY;
  localparam oag_cc_type CC_UNSIGNED_AT_MOST_TEST = CC_CARRY;
  localparam oag_cc_type CC_ABOVE_TEST = CC_NO_CARRY;
  localparam oag_cc_type CC_EQUAL = CC_ZERO;
  localparam oag_cc_type CC_NOT_EQUAL = CC_NOT_ZERO;

  typedef struct packed {
    logic [10:0] spare;
    logic [3:0] cc;
    logic [2:0] src;
    logic [2:0] dst;
    logic store;
    logic bank;
    logic [2:0] sel;
    logic [1:0] post;
    logic [3:0] mode;
  } oag_ctrl_type;

  typedef struct packed {
    logic [6:0] spare;
    logic [1:0] page;
    logic ie;
    logic user1;
    logic user0;
    logic ovf;
    logic sign;
    logic zero;
    logic carry;
  } oag_status_type;

  typedef struct packed {
    logic req;
    logic we;
    logic bank;
    logic [PW-1:0] addr;
    logic [DW-1:0] wdata;
  } oag_dram_type;

endpackage

// file: oag_operand_address_generator.sv
// Purpose: operand addressing and condition evaluation engine
// Assumes: data RAM and program memory on clk_i, one-cycle latency:
//   address taken at the edge with req high, data read one edge later
// Notes: register writes stall while an operation is in flight
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module oag_operand_address_generator #(
  parameter int LOOP_BITS = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [oag_pkg::AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output oag_pkg::oag_dram_type dram_o,
  input wire logic [oag_pkg::DW-1:0] dram_rdata_i,
  output logic pmem_req_o,
  output logic [oag_pkg::DW-1:0] pmem_addr_o,
  input wire logic [oag_pkg::DW-1:0] pmem_rdata_i,
  output logic busy_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DREQ,
    ST_DWAIT,
    ST_PREQ,
    ST_PWAIT,
    ST_FIN
  } oag_state_type;

  oag_state_type state;
  oag_pkg::oag_ctrl_type ctrl;
  oag_pkg::oag_status_type status;
  logic [oag_pkg::DW-1:0] operand;
  logic [oag_pkg::DW-1:0] acc;
  logic [oag_pkg::DW-1:0] result;
  logic [oag_pkg::PW-1:0] ptr [oag_pkg::NPTR];
  logic [oag_pkg::DW-1:0] ind_word;
  logic go;
  logic executed;
  logic skipped;
  logic refused;
  logic bus_wr;
  logic cond_ok;
  logic refuse;
  logic ptr_mode;
  logic ld_en;
  logic [2:0] ld_sel;
  logic [oag_pkg::DW-1:0] ld_val;
  logic upd_en;
  logic [oag_pkg::PW-1:0] upd_val;
  logic [oag_pkg::PW-1:0] sel_ptr;
  logic [oag_pkg::PW-1:0] dreg_addr;
  oag_pkg::oag_mode_type mode;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // returns NPTR when the address hits no pointer register
  function automatic logic [2:0] ptr_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - oag_pkg::REG_PTR_BASE;
    if (a >= oag_pkg::REG_PTR_BASE && d[1:0] == 2'h0 &&
        d[7:2] < 6'(oag_pkg::NPTR))
      return d[4:2];
    return 3'(oag_pkg::NPTR);
  endfunction

  function automatic logic [oag_pkg::DW-1:0] reg_read(input logic [2:0] s);
    logic [2:0] k;
    k = s - oag_pkg::SEL_PTR_FIRST;
    if (s == oag_pkg::SEL_ACC)
      return acc;
    if (s == oag_pkg::SEL_RESULT)
      return result;
    return {8'h00, ptr[k]};
  endfunction

  function automatic logic cond_true(input logic [3:0] cc,
                                     input oag_pkg::oag_status_type s);
    logic r;
    r = 1'b0;
    unique case (oag_pkg::oag_cc_type'(cc))
      oag_pkg::CC_ALWAYS: r = 1'b1;
      oag_pkg::CC_NEVER: r = 1'b0;
      oag_pkg::CC_CARRY: r = s.carry;
      oag_pkg::CC_NO_CARRY: r = !s.carry;
      oag_pkg::CC_ZERO: r = s.zero;
      oag_pkg::CC_NOT_ZERO: r = !s.zero;
      oag_pkg::CC_NEGATIVE_TEST: r = s.sign;
      oag_pkg::CC_POSITIVE_TEST: r = !s.sign;
      oag_pkg::CC_OVERFLOW_SET_TEST: r = s.ovf;
      oag_pkg::CC_OVERFLOW_CLEAR_TEST: r = !s.ovf;
      oag_pkg::CC_USER_FLAG_ZERO_TEST: r = s.user0;
      oag_pkg::CC_USER_FLAG_ZERO_CLEAR_TEST: r = !s.user0;
      oag_pkg::CC_USER_FLAG_ONE_TEST: r = s.user1;
      oag_pkg::CC_USER_FLAG_ONE_CLEAR_TEST: r = !s.user1;
      oag_pkg::CC_INTERRUPTS_ON_TEST: r = s.ie;
      oag_pkg::CC_INTERRUPTS_OFF_TEST: r = !s.ie;
    endcase
    return r;
  endfunction

  // loop variants wrap inside an aligned window of 2**LOOP_BITS words
  function automatic logic [oag_pkg::PW-1:0] post_update(
    input logic [oag_pkg::PW-1:0] p, input logic [1:0] op);
    logic [oag_pkg::PW-1:0] r;
    r = p;
    unique case (oag_pkg::oag_post_type'(op))
      oag_pkg::POST_NONE: r = p;
      oag_pkg::POST_INC: r = p + oag_pkg::PTR_STEP;
      oag_pkg::POST_LOOP_INC: r[LOOP_BITS-1:0] =
        p[LOOP_BITS-1:0] + LOOP_BITS'(1);
      oag_pkg::POST_LOOP_DEC: r[LOOP_BITS-1:0] =
        p[LOOP_BITS-1:0] - LOOP_BITS'(1);
    endcase
    return r;
  endfunction

  assign bus_wr = avs_write_i && !avs_waitrequest_o;
  assign mode = oag_pkg::oag_mode_type'(ctrl.mode);
  assign sel_ptr = ptr[ctrl.sel];
  assign dreg_addr = {oag_pkg::DREG_PAD[7:4], status.page,
                      ctrl.sel[1:0]};
  assign cond_ok = cond_true(ctrl.cc, status);
  assign ptr_mode = (mode == oag_pkg::MODE_PTR_IND) ||
                    (mode == oag_pkg::MODE_PTR_MEM);

  always_comb
  begin
    refuse = 1'b0;
    if (ctrl.mode > 4'(oag_pkg::MODE_SHORT_IMM))
      refuse = 1'b1;
    else if (ptr_mode && ctrl.sel >= 3'(oag_pkg::NPTR))
      refuse = 1'b1;
    // program memory is read-only through these modes
    else if (ctrl.store && (mode == oag_pkg::MODE_PTR_MEM ||
             mode == oag_pkg::MODE_DREG_MEM ||
             mode == oag_pkg::MODE_ACC_IND))
      refuse = 1'b1;
    else if (mode == oag_pkg::MODE_SHORT_IMM &&
             (ctrl.dst == oag_pkg::SEL_ACC ||
              ctrl.dst == oag_pkg::SEL_RESULT))
      refuse = 1'b1;
  end

  // bus slave: one waitrequest-low cycle per access
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      ctrl <= '0;
      operand <= 16'h0000;
      go <= 1'b0;
    end
    else
    begin
      go <= 1'b0;
      if (!avs_waitrequest_o)
        avs_waitrequest_o <= 1'b1;
      else if (avs_read_i)
      begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= 32'h0000_0000;
        case (avs_address_i)
          oag_pkg::REG_CTRL: avs_readdata_o <= ctrl;
          oag_pkg::REG_OPERAND: avs_readdata_o[15:0] <= operand;
          oag_pkg::REG_STATUS: avs_readdata_o[15:0] <= status;
          oag_pkg::REG_ACC: avs_readdata_o[15:0] <= acc;
          oag_pkg::REG_RESULT: avs_readdata_o[15:0] <= result;
          oag_pkg::REG_INFO: avs_readdata_o[3:0] <=
            {busy_o, refused, skipped, executed};
          default:
            if (ptr_index(avs_address_i) != 3'(oag_pkg::NPTR))
              avs_readdata_o[7:0] <= ptr[ptr_index(avs_address_i)];
        endcase
      end
      // writes wait until the engine is idle so state never has two owners
      else if (avs_write_i && !busy_o && !go)
        avs_waitrequest_o <= 1'b0;
      if (bus_wr && avs_address_i == oag_pkg::REG_CTRL)
      begin
        ctrl <= be_merge(ctrl, avs_writedata_i, avs_byteenable_i);
        go <= 1'b1;
      end
      if (bus_wr && avs_address_i == oag_pkg::REG_OPERAND)
        operand <= 16'(be_merge({16'h0000, operand}, avs_writedata_i,
                                avs_byteenable_i));
    end
  end

  // register loads requested by the engine
  always_comb
  begin
    ld_en = 1'b0;
    ld_sel = ctrl.dst;
    ld_val = 16'h0000;
    upd_en = 1'b0;
    upd_val = post_update(sel_ptr, ctrl.post);
    unique case (state)
      ST_IDLE:
        if (go && cond_ok && !refuse)
        begin
          if (mode == oag_pkg::MODE_REG_MOVE)
          begin
            ld_en = 1'b1;
            ld_val = reg_read(ctrl.src);
          end
          else if (mode == oag_pkg::MODE_LONG_IMM)
          begin
            ld_en = 1'b1;
            ld_val = operand;
          end
          else if (mode == oag_pkg::MODE_SHORT_IMM)
          begin
            ld_en = 1'b1;
            ld_val = {8'h00, operand[7:0]};
          end
        end
      ST_DWAIT:
        if (mode != oag_pkg::MODE_PTR_MEM && mode != oag_pkg::MODE_DREG_MEM)
        begin
          ld_en = 1'b1;
          ld_val = dram_rdata_i;
          if (mode == oag_pkg::MODE_DIRECT)
            ld_sel = oag_pkg::SEL_ACC;
        end
      ST_PWAIT:
      begin
        ld_en = 1'b1;
        ld_val = pmem_rdata_i;
      end
      ST_FIN:
        upd_en = executed && ptr_mode;
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc <= 16'h0000;
      result <= 16'h0000;
      status <= '0;
      for (int i = 0; i < oag_pkg::NPTR; i++)
        ptr[i] <= 8'h00;
    end
    else if (bus_wr)
    begin
      if (avs_address_i == oag_pkg::REG_ACC)
        acc <= 16'(be_merge({16'h0000, acc}, avs_writedata_i,
                            avs_byteenable_i));
      if (avs_address_i == oag_pkg::REG_STATUS)
        status <= 16'(be_merge({16'h0000, status}, avs_writedata_i,
                               avs_byteenable_i)) & 16'h01ff;
      if (ptr_index(avs_address_i) != 3'(oag_pkg::NPTR) &&
          avs_byteenable_i[0])
        ptr[ptr_index(avs_address_i)] <= avs_writedata_i[7:0];
    end
    else
    begin
      if (ld_en)
      begin
        if (ld_sel == oag_pkg::SEL_ACC)
          acc <= ld_val;
        else if (ld_sel == oag_pkg::SEL_RESULT)
          result <= ld_val;
        else if (ld_sel - oag_pkg::SEL_PTR_FIRST < 3'(oag_pkg::NPTR))
          ptr[ld_sel - oag_pkg::SEL_PTR_FIRST] <= ld_val[7:0];
      end
      if (upd_en)
        ptr[ctrl.sel] <= upd_val;
    end
  end

  // sequencer and memory ports
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= ST_IDLE;
      dram_o <= '0;
      pmem_req_o <= 1'b0;
      pmem_addr_o <= 16'h0000;
      ind_word <= 16'h0000;
      executed <= 1'b0;
      skipped <= 1'b0;
      refused <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          if (go)
          begin
            busy_o <= 1'b1;
            executed <= 1'b0;
            skipped <= 1'b0;
            refused <= 1'b0;
            state <= ST_FIN;
            if (!cond_ok)
              skipped <= 1'b1;
            else if (refuse)
              refused <= 1'b1;
            else
            begin
              executed <= 1'b1;
              dram_o.bank <= ctrl.bank;
              dram_o.wdata <= acc;
              dram_o.we <= 1'b0;
              unique case (mode)
                oag_pkg::MODE_PTR_IND, oag_pkg::MODE_PTR_MEM:
                begin
                  dram_o.req <= 1'b1;
                  dram_o.addr <= sel_ptr;
                  dram_o.we <= ctrl.store && mode == oag_pkg::MODE_PTR_IND;
                  state <= ST_DREQ;
                end
                oag_pkg::MODE_DREG, oag_pkg::MODE_DREG_MEM:
                begin
                  dram_o.req <= 1'b1;
                  dram_o.addr <= dreg_addr;
                  dram_o.we <= ctrl.store && mode == oag_pkg::MODE_DREG;
                  state <= ST_DREQ;
                end
                oag_pkg::MODE_DIRECT:
                begin
                  dram_o.req <= 1'b1;
                  dram_o.addr <= operand[7:0];
                  dram_o.bank <= operand[8];
                  dram_o.we <= ctrl.store;
                  state <= ST_DREQ;
                end
                oag_pkg::MODE_ACC_IND:
                begin
                  pmem_req_o <= 1'b1;
                  pmem_addr_o <= acc;
                  state <= ST_PREQ;
                end
                default:
                  state <= ST_FIN;
              endcase
            end
          end
        ST_DREQ:
        begin
          dram_o.req <= 1'b0;
          state <= dram_o.we ? ST_FIN : ST_DWAIT;
        end
        ST_DWAIT:
          if (mode == oag_pkg::MODE_PTR_MEM || mode == oag_pkg::MODE_DREG_MEM)
          begin
            pmem_req_o <= 1'b1;
            pmem_addr_o <= dram_rdata_i;
            ind_word <= dram_rdata_i;
            state <= ST_PREQ;
          end
          else
            state <= ST_FIN;
        ST_PREQ:
        begin
          pmem_req_o <= 1'b0;
          state <= ST_PWAIT;
        end
        ST_PWAIT:
          if (mode == oag_pkg::MODE_PTR_MEM || mode == oag_pkg::MODE_DREG_MEM)
          begin
            // write-back reuses the held RAM address and bank
            dram_o.req <= 1'b1;
            dram_o.we <= 1'b1;
            dram_o.wdata <= ind_word + oag_pkg::PM_STEP;
            state <= ST_DREQ;
          end
          else
            state <= ST_FIN;
        ST_FIN:
        begin
          busy_o <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: oag_monitor.sv
// Purpose: port checker for the operand address generator
// Assumes: software writes full 32-bit words
// Notes: shadows ctrl, operand and status to judge addresses
`timescale 1ns/1ps
module oag_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [oag_pkg::AW-1:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire oag_pkg::oag_dram_type dram_o,
  input wire logic [oag_pkg::DW-1:0] dram_rdata_i,
  input wire logic pmem_req_o,
  input wire logic [oag_pkg::DW-1:0] pmem_addr_o,
  input wire logic busy_o
);
  logic [31:0] ctrl_q;
  logic [15:0] opnd_q;
  logic [15:0] stat_q;
  logic [15:0] rd_cap;
  logic rd_d;
  logic take;
  logic [3:0] mode;
  logic memind;
  assign take = avs_write_i && !avs_waitrequest_o;
  assign mode = ctrl_q[3:0];
  assign memind = mode == oag_pkg::MODE_PTR_MEM ||
                  mode == oag_pkg::MODE_DREG_MEM;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_q <= 32'h0;
      opnd_q <= 16'h0;
      stat_q <= 16'h0;
      rd_d <= 1'b0;
      rd_cap <= 16'h0;
    end
    else
    begin
      if (take && avs_address_i == oag_pkg::REG_CTRL)
        ctrl_q <= avs_writedata_i;
      if (take && avs_address_i == oag_pkg::REG_OPERAND)
        opnd_q <= avs_writedata_i[15:0];
      if (take && avs_address_i == oag_pkg::REG_STATUS)
        stat_q <= avs_writedata_i[15:0];
      // ram answers one edge after the request edge
      rd_d <= dram_o.req && !dram_o.we;
      if (rd_d)
        rd_cap <= dram_rdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wait_one_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  dram_pulse_a: assert property (dram_o.req |=> !dram_o.req)
    else $error("ram request longer than one cycle");
  busy_start_a: assert property (take && avs_address_i == oag_pkg::REG_CTRL
    |-> ##[1:3] busy_o) else $error("busy did not follow a ctrl write");
  incr_store_a: assert property (pmem_req_o && memind |-> ##[2:4]
    (dram_o.req && dram_o.we && dram_o.wdata == pmem_addr_o + 16'h0001))
    else $error("stored program address not advanced");
  memind_read_a: assert property (dram_o.req && !dram_o.we
    && memind |-> ##[2:4] (pmem_req_o && pmem_addr_o == rd_cap))
    else $error("program address is not the ram word");
  direct_addr_a: assert property (dram_o.req && mode ==
    oag_pkg::MODE_DIRECT |-> dram_o.addr == opnd_q[7:0] &&
    dram_o.bank == opnd_q[8]) else $error("direct address wrong");
  dreg_addr_a: assert property (dram_o.req && (mode ==
    oag_pkg::MODE_DREG || mode == oag_pkg::MODE_DREG_MEM) |->
    dram_o.addr == {4'h0, stat_q[8:7], ctrl_q[7:6]})
    else $error("data register address wrong");
  bank_sel_a: assert property (dram_o.req && mode !=
    oag_pkg::MODE_DIRECT |-> dram_o.bank == ctrl_q[9])
    else $error("bank suffix ignored");
  never_quiet_a: assert property (busy_o && ctrl_q[20:17] ==
    oag_pkg::CC_NEVER |-> !dram_o.req && !pmem_req_o)
    else $error("memory traffic under a false condition");
endmodule
bind oag_operand_address_generator oag_monitor i_oag_monitor (.clk_i,
  .nrst_i, .avs_address_i, .avs_write_i, .avs_writedata_i,
  .avs_waitrequest_o, .dram_o, .dram_rdata_i, .pmem_req_o, .pmem_addr_o,
  .busy_o);

// file: oag_mem_model.sv
// Purpose: data ram banks and program memory beside the block
// Assumes: one-cycle read latency on clk_i
// Notes: program word is its address xor a fixed pattern
`timescale 1ns/1ps
module oag_mem_model (
  input wire logic clk_i,
  input wire oag_pkg::oag_dram_type dram_i,
  output logic [15:0] dram_rdata_o,
  input wire logic pmem_req_i,
  input wire logic [15:0] pmem_addr_i,
  output logic [15:0] pmem_rdata_o
);
  logic [15:0] ram [2][256];
  initial
  begin
    dram_rdata_o = 16'h0000;
    pmem_rdata_o = 16'h0000;
  end
  // stale data flips so a late sample shows up
  always @(posedge clk_i)
  begin
    if (dram_i.req && dram_i.we)
      ram[dram_i.bank][dram_i.addr] <= dram_i.wdata;
    if (dram_i.req)
      dram_rdata_o <= ram[dram_i.bank][dram_i.addr];
    else
      dram_rdata_o <= ~dram_rdata_o;
    if (pmem_req_i)
      pmem_rdata_o <= pmem_addr_i ^ 16'hc3a5;
    else
      pmem_rdata_o <= ~pmem_rdata_o;
  end
endmodule

// file: tb.sv
// Purpose: register-level regression of the address generator
// Assumes: Avalon-MM master, full byte enables
// Notes: every op is followed by a wait for busy to drop
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, v;
  logic wreq, pmrq, busy;
  oag_pkg::oag_dram_type dram;
  logic [15:0] drd, pmrd, pma;
  int fails = 0;
  int comparisons = 0;
  logic [7:0] st [4] = '{8'h20, 8'h2f, 8'h2f, 8'h20};
  logic [7:0] nx [4] = '{8'h20, 8'h30, 8'h20, 8'h2f};
  logic [7:0] regs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h18};
  // distinct flag patterns so swapped tests show up
  logic [6:0] flg [3] = '{7'h00, 7'h7f, 7'h55};
  initial
    forever #12.5 clk_i = ~clk_i;
  oag_operand_address_generator #(.LOOP_BITS(4))
    i_oag_operand_address_generator (.clk_i, .nrst_i,
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .dram_o(dram),
    .dram_rdata_i(drd), .pmem_req_o(pmrq), .pmem_addr_o(pma),
    .pmem_rdata_i(pmrd), .busy_o(busy));
  oag_mem_model i_oag_mem_model (.clk_i, .dram_i(dram),
    .dram_rdata_o(drd), .pmem_req_i(pmrq), .pmem_addr_i(pma),
    .pmem_rdata_o(pmrd));
  task automatic final_report();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for the slave to drop waitrequest
  task automatic wait_ack();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 200);
    if (wreq !== 1'b0)
    begin
      fails++;
      final_report();
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    wdat <= d;
    wr <= 1'b1;
    wait_ack();
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    rd <= 1'b1;
    wait_ack();
    d = rdat;
    rd <= 1'b0;
  endtask
  // busy rises one edge after the ctrl write is taken
  task automatic op(input logic [31:0] c);
    int n;
    bus_wr(oag_pkg::REG_CTRL, c);
    repeat (3) @(posedge clk_i);
    for (n = 0; busy !== 1'b0 && n < 50; n++)
      @(posedge clk_i);
    if (busy !== 1'b0)
    begin
      fails++;
      final_report();
    end
  endtask
  function automatic logic [31:0] mk(input logic [3:0] md,
      input logic [1:0] po, input logic [2:0] sl, input logic bk,
      input logic so, input logic [2:0] ds, input logic [3:0] cc);
    return {11'h0, cc, 3'h0, ds, so, bk, sl, po, md};
  endfunction
  function automatic logic cond(input logic [3:0] c, input logic [6:0] s);
    logic [7:0] t;
    t = {s, 1'b1};
    return t[c[3:1]] ^ c[0];
  endfunction
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a, v);
    check(v, e);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (regs[i])
      rd_chk(regs[i], 32'h0);
    $display("test reset done");
    bus_wr(oag_pkg::REG_OPERAND, 32'hbeef);
    op(mk(4'h7, 2'h0, 3'h0, 1'b0, 1'b0, 3'h0, 4'h0));
    rd_chk(oag_pkg::REG_ACC, 32'hbeef);
    op(mk(4'h0, 2'h0, 3'h0, 1'b0, 1'b0, 3'h7, 4'h0));
    rd_chk(oag_pkg::REG_RESULT, 32'hbeef);
    op(mk(4'h8, 2'h0, 3'h0, 1'b0, 1'b0, 3'h1, 4'h0));
    rd_chk(oag_pkg::REG_PTR_BASE, 32'hef);
    op(mk(4'h8, 2'h0, 3'h0, 1'b0, 1'b0, 3'h0, 4'h0));
    rd_chk(oag_pkg::REG_INFO, 32'h4);
    rd_chk(oag_pkg::REG_ACC, 32'hbeef);
    $display("test immediates done");
    for (int p = 0; p < 4; p++)
    begin
      bus_wr(8'h24, {24'h0, st[p]});
      i_oag_mem_model.ram[1][st[p]] = 16'h1000 + p;
      i_oag_mem_model.ram[0][st[p]] = 16'h2000;
      op(mk(4'h1, 2'(p), 3'h1, 1'b1, 1'b0, 3'h7, 4'h0));
      rd_chk(oag_pkg::REG_RESULT, 32'h1000 + p);
      rd_chk(8'h24, {24'h0, nx[p]});
    end
    $display("test pointer done");
    bus_wr(oag_pkg::REG_ACC, 32'h55aa);
    bus_wr(oag_pkg::REG_OPERAND, 32'h0123);
    op(mk(4'h6, 2'h0, 3'h0, 1'b0, 1'b1, 3'h0, 4'h0));
    check(i_oag_mem_model.ram[1][8'h23], 32'h55aa);
    i_oag_mem_model.ram[0][8'hff] = 16'h6789;
    bus_wr(oag_pkg::REG_OPERAND, 32'h00ff);
    op(mk(4'h6, 2'h0, 3'h0, 1'b0, 1'b0, 3'h0, 4'h0));
    rd_chk(oag_pkg::REG_ACC, 32'h6789);
    $display("test direct done");
    bus_wr(oag_pkg::REG_STATUS, 32'h0100);
    i_oag_mem_model.ram[0][8'h0b] = 16'h4321;
    op(mk(4'h2, 2'h0, 3'h3, 1'b0, 1'b0, 3'h7, 4'h0));
    rd_chk(oag_pkg::REG_RESULT, 32'h4321);
    bus_wr(8'h28, 32'h40);
    i_oag_mem_model.ram[0][8'h40] = 16'h0200;
    for (int i = 0; i < 2; i++)
    begin
      op(mk(4'h3, 2'h0, 3'h2, 1'b0, 1'b0, 3'h7, 4'h0));
      rd_chk(oag_pkg::REG_RESULT, (32'h0200 + i) ^ 32'hc3a5);
    end
    check(i_oag_mem_model.ram[0][8'h40], 32'h0202);
    // a store through program memory is refused, a false test skips
    op(mk(4'h3, 2'h1, 3'h2, 1'b0, 1'b1, 3'h7, 4'h0));
    rd_chk(oag_pkg::REG_INFO, 32'h4);
    op(mk(4'h3, 2'h1, 3'h2, 1'b0, 1'b0, 3'h7, 4'h1));
    rd_chk(oag_pkg::REG_INFO, 32'h2);
    rd_chk(8'h28, 32'h40);
    check(i_oag_mem_model.ram[0][8'h40], 32'h0202);
    i_oag_mem_model.ram[1][8'h0a] = 16'h0300;
    op(mk(4'h4, 2'h0, 3'h2, 1'b1, 1'b0, 3'h7, 4'h0));
    rd_chk(oag_pkg::REG_RESULT, 32'h0300 ^ 32'hc3a5);
    check(i_oag_mem_model.ram[1][8'h0a], 32'h0301);
    bus_wr(oag_pkg::REG_ACC, 32'h0777);
    op(mk(4'h5, 2'h0, 3'h0, 1'b0, 1'b0, 3'h7, 4'h0));
    rd_chk(oag_pkg::REG_RESULT, 32'h0777 ^ 32'hc3a5);
    $display("test memory indirect done");
    for (int s = 0; s < 3; s++)
    begin
      bus_wr(oag_pkg::REG_STATUS, {25'h0, flg[s]});
      for (int c = 0; c < 16; c++)
      begin
        bus_wr(oag_pkg::REG_ACC, 32'h0);
        bus_wr(oag_pkg::REG_OPERAND, c + 1);
        op(mk(4'h7, 2'h0, 3'h0, 1'b0, 1'b0, 3'h0, 4'(c)));
        v = cond(4'(c), flg[s]) ? c + 1 : 0;
        rd_chk(oag_pkg::REG_ACC, v);
      end
    end
    $display("test conditions done");
    final_report();
  end
endmodule
